// File: verification/id_mask_checker.sv
// Checker of the filter's result pulses and read data timing.
// Assumes it is bound to id_mask_filter and sees only its ports.
`timescale 1ns/1ps
module id_mask_checker
(
  input wire logic clk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic reg_rd, // Read strobe
  input wire logic [7:0] reg_rdata, // Read data
  input wire logic [id_mask_pkg::ID_W-1:0] rx_ident, // Identifier
  input wire logic [id_mask_pkg::ID_W-1:0] accept_code, // Code
  input wire logic rx_valid, // Identifier valid
  input wire logic accept, // Match pulse
  input wire logic reject // Mismatch pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Result timing and meaning
  property p_answer;
    rx_valid |=> accept ^ reject;
  endproperty
  a_answer: assert property (p_answer) else $error("no single result");
  property p_quiet;
    !rx_valid |=> !(accept || reject);
  endproperty
  a_quiet: assert property (p_quiet) else $error("stray result");
  property p_equal;
    rx_valid && rx_ident == accept_code |=> accept;
  endproperty
  a_equal: assert property (p_equal) else $error("equal id refused");
  property p_src;
    reject |-> $past(rx_ident) != $past(accept_code);
  endproperty
  a_src: assert property (p_src) else $error("reject without mismatch");
  property p_rdidle;
    !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_rdidle: assert property (p_rdidle) else $error("read data outside slot");
endmodule : id_mask_checker

// File: verification/id_mask_filter_tb.sv
// Bench for the mask filter: register port, receiver model, checks.
// Assumes design, checker and model files are compiled first.
`timescale 1ns/1ps
module id_mask_filter_tb;
  logic clk = 0, sys_rst = 1, soft_reset_bit = 0, reg_wr = 0, reg_rd = 0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic [31:0] rx_ident, accept_code, m_exp, a, b, lfsr = 32'h0000_454d;
  logic rx_valid, accept, reject, last_ok;
  int failures = 0, n_tests = 0;
  id_mask_filter dut (.*);
  rx_model m (.clk(clk), .rx_ident(rx_ident), .accept_code(accept_code), .rx_valid(rx_valid));
  initial forever #2.5 clk = ~clk;
  function automatic logic [31:0] nx(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : nx
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input int i, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= id_mask_pkg::ADDR_ID_MASK_0 + 16'(i);
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input int i, input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= id_mask_pkg::ADDR_ID_MASK_0 + 16'(i);
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk({24'h0, reg_rdata}, {24'h0, e});
  endtask : rd
  // Result expected from the tracked mask
  task automatic flt(input logic [31:0] id, input logic [31:0] cd);
    logic ok;
    ok = ((id ^ cd) & ~m_exp) == 32'h0;
    last_ok = ok;
    m.send(id, cd);
    chk({30'h0, accept, reject}, {30'h0, ok, ~ok});
  endtask : flt
  task automatic wrap_up;
    if (failures == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  // Main sequence: load masks, refused writes, reset, filtering
  initial
  begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    soft_reset_bit <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      lfsr = nx(lfsr);
      m_exp[8*i+:8] = lfsr[7:0];
      wr(i, lfsr[7:0]);
    end
    soft_reset_bit <= 1'b0;
    for (int i = 0; i < 4; i++)
      wr(i, ~m_exp[8*i+:8]);
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 4; i++)
      rd(i, m_exp[8*i+:8]);
    rd(5, 8'h00);
    rd(4, 8'h00);
    for (int i = 0; i < 32; i++)
      flt(lfsr, lfsr ^ (32'h1 << i));
    for (int i = 0; i < 40; i++)
    begin
      a = nx(lfsr);
      b = nx(a);
      lfsr = b;
      flt(a, a ^ (b & ((i % 2) ? m_exp : 32'hffff_ffff)));
    end
    rd(4, {6'h00, 1'b1, last_ok});
    wrap_up();
  end
endmodule : id_mask_filter_tb
bind id_mask_filter id_mask_checker chk_i (.clk(clk), .sys_rst(sys_rst), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .rx_ident(rx_ident), .accept_code(accept_code),
  .rx_valid(rx_valid), .accept(accept), .reject(reject));

// File: verification/rx_model.sv
// Receiver model: offers identifier and code with a one-cycle valid.
// Assumes the caller runs send from one process at a time.
`timescale 1ns/1ps
module rx_model
(
  input wire logic clk, // Clock
  output logic [id_mask_pkg::ID_W-1:0] rx_ident = '0, // Identifier
  output logic [id_mask_pkg::ID_W-1:0] accept_code = '0, // Code
  output logic rx_valid = 1'b0 // Valid pulse
);
  // Lines change off the last value once valid drops, so stale data shows
  task automatic send(input logic [31:0] id, input logic [31:0] cd);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_ident <= id;
    accept_code <= cd;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_ident <= ~id;
    accept_code <= ~cd;
    #1;
  endtask : send
endmodule : rx_model

// File: verilog/id_mask_filter.sv
// Identifier acceptance mask filter for a CAN receive path.
// Assumes the receiver presents identifier and acceptance code together
// with a one-cycle valid, all on clk; soft reset comes from control logic.
`timescale 1ns/1ps

module id_mask_filter
(
  input wire logic clk, // System clock, 200 MHz
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic soft_reset_bit, // Soft reset state of module_control_0
  input wire logic [15:0] reg_addr, // Register address
  input wire logic [7:0] reg_wdata, // Register write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [7:0] reg_rdata, // Read data, cycle after strobe
  input wire logic [id_mask_pkg::ID_W-1:0] rx_ident, // Received identifier bits
  input wire logic [id_mask_pkg::ID_W-1:0] accept_code, // Acceptance code bits
  input wire logic rx_valid, // Identifier valid, one cycle
  output logic accept, // Match result pulse
  output logic reject // Mismatch result pulse
);

  id_mask_pkg::reg_req_s req; // Register port request, bundled
  id_mask_pkg::id_req_s idr; // Identifier offer, bundled
  logic [id_mask_pkg::ID_W-1:0] accept_mask_bits; // All mask bits, flat
  logic [1:0] widx; // Mask byte named by the address
  logic mask_hit; // Address names a mask byte
  logic stat_hit; // Address names the status byte
  logic mask_we; // Qualified mask write
  logic [id_mask_pkg::MASK_REGS-1:0] byte_ok; // Per byte agreement
  logic last_match_r; // Outcome of the latest identifier
  logic last_valid_r; // At least one identifier judged
  logic match_now; // Whole identifier accepted
  logic [7:0] mask_byte; // Mask byte picked for a read
  logic [7:0] stat_byte; // Status byte as it reads now
  logic [7:0] rdata_nxt; // Next read data

  // ==========================================================================
  // Bundle inputs
  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign idr = '{ident: rx_ident, code: accept_code, valid: rx_valid};

  // Decode of a mask address, used for both writes and reads
  function automatic logic is_mask(input logic [15:0] a);
    is_mask = (a == id_mask_pkg::ADDR_ID_MASK_0) || (a == id_mask_pkg::ADDR_ID_MASK_1)
      || (a == id_mask_pkg::ADDR_ID_MASK_2) || (a == id_mask_pkg::ADDR_ID_MASK_3);
  endfunction : is_mask

  // Index of a mask byte from its address
  function automatic logic [1:0] mask_index(input logic [15:0] a);
    logic [15:0] d;
    d = a - id_mask_pkg::ADDR_ID_MASK_0;
    mask_index = d[1:0];
  endfunction : mask_index

  // Decode of the status address
  function automatic logic is_status(input logic [15:0] a);
    is_status = (a == id_mask_pkg::ADDR_ACCEPT_STATUS);
  endfunction : is_status

  // One byte out of a flat word, byte 0 lowest
  function automatic logic [id_mask_pkg::REG_W-1:0] pick_byte(
    input logic [id_mask_pkg::ID_W-1:0] word,
    input logic [1:0] idx);
    pick_byte = word[idx*id_mask_pkg::REG_W +: id_mask_pkg::REG_W];
  endfunction : pick_byte

  // Agreement of one byte: a set mask bit passes, a clear one compares
  function automatic logic byte_match(
    input logic [id_mask_pkg::REG_W-1:0] ident,
    input logic [id_mask_pkg::REG_W-1:0] code,
    input logic [id_mask_pkg::REG_W-1:0] mask);
    byte_match = &((~(ident ^ code)) | mask);
  endfunction : byte_match

  // ==========================================================================
  // Register write gating
  assign mask_hit = is_mask(req.addr);
  assign stat_hit = is_status(req.addr);
  assign widx = mask_index(req.addr);
  assign mask_we = req.wr && mask_hit && soft_reset_bit;

  id_mask_store u_store
  (
    .clk(clk),
    .we(mask_we),
    .waddr(widx),
    .wdata(req.wdata),
    .raddr(widx),
    .rdata(), // Unused: read data comes from the flat bus into one flop
    .mask_all(accept_mask_bits)
  );

  // ==========================================================================
  // Match per byte: a set mask bit ignores the position, a clear one compares
  always_comb
  begin
    for (int i = 0; i < id_mask_pkg::MASK_REGS; i++)
    begin
      byte_ok[i] = byte_match(pick_byte(idr.ident, 2'(i)), pick_byte(idr.code, 2'(i)),
        pick_byte(accept_mask_bits, 2'(i)));
    end
  end

  // Whole identifier: one unmasked mismatch in any byte rejects
  assign match_now = &byte_ok;

  // Result pulses, one cycle after the valid identifier
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      accept <= 1'b0;
      reject <= 1'b0;
    end
    else
    begin
      accept <= idr.valid && match_now;
      reject <= idr.valid && !match_now;
    end
  end

  // Last result, kept for the status register
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      last_match_r <= 1'b0;
      last_valid_r <= 1'b0;
    end
    else if (idr.valid)
    begin
      last_match_r <= match_now;
      last_valid_r <= 1'b1;
    end
  end

  // ==========================================================================
  // Read side: mask byte as it stands at the strobe, so a write in the same cycle is not seen
  assign mask_byte = pick_byte(accept_mask_bits, widx);

  // Status byte: latest outcome and whether any identifier was judged
  always_comb
  begin
    stat_byte = id_mask_pkg::READ_ZERO;
    stat_byte[id_mask_pkg::STAT_MATCH_BIT] = last_match_r;
    stat_byte[id_mask_pkg::STAT_VALID_BIT] = last_valid_r;
  end

  // Next read data, zero outside a read slot and for unmapped addresses
  always_comb
  begin
    rdata_nxt = id_mask_pkg::READ_ZERO;
    if (req.rd && mask_hit)
    begin
      rdata_nxt = mask_byte;
    end
    else if (req.rd && stat_hit)
    begin
      rdata_nxt = stat_byte;
    end
  end

  // Read data register: stands only in the cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      reg_rdata <= id_mask_pkg::READ_ZERO;
    end
    else
    begin
      reg_rdata <= rdata_nxt;
    end
  end

endmodule : id_mask_filter

// File: verilog/id_mask_pkg.sv
// Package for the identifier mask filter: register map and carriers.
// Assumes a byte-wide register port and a 32-bit received identifier.
package id_mask_pkg;

  // ==========================================================================
  // Register indices (byte addresses on the plain register port)
  localparam logic [15:0] ADDR_ID_MASK_0 = 16'h0514;
  localparam logic [15:0] ADDR_ID_MASK_1 = 16'h0515;
  localparam logic [15:0] ADDR_ID_MASK_2 = 16'h0516;
  localparam logic [15:0] ADDR_ID_MASK_3 = 16'h0517;
  localparam logic [15:0] ADDR_ACCEPT_STATUS = 16'h0518;

  // ==========================================================================
  // Widths and field positions
  localparam int unsigned MASK_REGS = 4;
  localparam int unsigned REG_W = 8;
  localparam int unsigned ID_W = MASK_REGS * REG_W;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam int unsigned STAT_MATCH_BIT = 0;
  localparam int unsigned STAT_VALID_BIT = 1;

  // ==========================================================================
  // Register port request
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  // Received identifier with its code, as offered by the receiver
  typedef struct packed {
    logic [ID_W-1:0] ident;
    logic [ID_W-1:0] code;
    logic valid;
  } id_req_s;

endpackage : id_mask_pkg

// File: verilog/id_mask_store.sv
// Storage of the four identifier mask bytes, with registered read data.
// Assumes the write enable is already qualified by the soft reset bit.
`timescale 1ns/1ps

module id_mask_store
(
  input wire logic clk, // System clock
  input wire logic we, // Qualified write enable
  input wire logic [1:0] waddr, // Byte to write
  input wire logic [7:0] wdata, // Byte written
  input wire logic [1:0] raddr, // Byte to read
  output logic [7:0] rdata, // Registered read byte
  output logic [id_mask_pkg::ID_W-1:0] mask_all // All mask bits, flat
);

  logic [7:0] mem_r [0:id_mask_pkg::MASK_REGS-1];

  // ==========================================================================
  // Mask storage: no reset at all, contents survive every reset
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem_r[waddr] <= wdata;
    end
  end

  // Registered read port
  always_ff @(posedge clk)
  begin
    rdata <= mem_r[raddr];
  end

  // Flatten, byte 0 holds the lowest mask bits
  always_comb
  begin
    for (int i = 0; i < id_mask_pkg::MASK_REGS; i++)
    begin
      mask_all[i*id_mask_pkg::REG_W +: id_mask_pkg::REG_W] = mem_r[i];
    end
  end

endmodule : id_mask_store
